// ---- logic/ioc_pkg.sv ----
// package: constants and types shared by the io cell storage path
// Summary of operation
// - with early capture, pad data latches on early clock, then moves on core clock.
// - pad output takes output data or clock enable, chosen by output clock level.
// - alternatively the output multiplexer acts as a fast two-input AND gate.
// - each fabric input output picks direct pad or input storage element, separately.
// - one shared clock enable, applied to input element, output element, or both.
// - the shared clock enable is never inverted inside the cell.
// - global set/reset loads configured set/reset value; async reset always loads 0.
// - unconnected clock enable acts high; low enable holds in flop and latch modes.
`default_nettype none

package ioc_pkg;

  // which storage elements the shared clock enable steers
  typedef enum logic [1:0] {
    IOC_CE_INPUT,
    IOC_CE_OUTPUT,
    IOC_CE_BOTH,
    IOC_CE_NONE
  } ioc_ce_sel_e;

  // value every storage element holds after asynchronous reset
  localparam logic IOC_RESET_VALUE = 1'h0;
  // level assumed on an unconnected clock enable
  localparam logic IOC_CE_UNCONNECTED = 1'h1;

endpackage : ioc_pkg

`default_nettype wire

// ---- logic/ioc_storage.sv ----
// module: one storage element, flip-flop or latch, with hold and set/reset
`default_nettype none

module ioc_storage
  import ioc_pkg::*;
(
  input  wire logic i_core_clk,   // core clock
  input  wire logic i_rst,        // async reset, active high
  input  wire logic i_elem_clk,   // element clock level, synchronous
  input  wire logic i_ce,         // effective clock enable
  input  wire logic i_d,          // data in
  input  wire logic i_latch_mode, // 1 = latch, 0 = flip-flop
  input  wire logic i_gsr,        // global set/reset pulse or level
  input  wire logic i_set_val,    // configured set/reset value
  output logic      o_q           // stored value
);
  import ioc_pkg::*;

  typedef struct packed {
    logic clk_prev;
    logic q;
  } ioc_stor_s;

  ioc_stor_s st_r;
  ioc_stor_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next state: gsr dominates, then enable gates any update
  always_comb begin
    st_nxt          = st_r;
    st_nxt.clk_prev = i_elem_clk;
    if (i_gsr) begin
      st_nxt.q = i_set_val;
    end else if (i_ce) begin
      if (i_latch_mode) begin
        // latch is transparent while its clock is low
        if (!i_elem_clk) begin
          st_nxt.q = i_d;
        end
      end else if (i_elem_clk && !st_r.clk_prev) begin
        st_nxt.q = i_d;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{clk_prev: 1'h0, q: IOC_RESET_VALUE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.q;

  ////////////////////////////////////////////////////////////////////////////
  AST_HOLD_WHEN_DISABLED: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (!i_ce && !i_gsr) |=> (o_q == $past(o_q)))
    else $error("storage changed while clock enable low");

  AST_GSR_LOADS_SET: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_gsr |=> (o_q == $past(i_set_val)))
    else $error("global set/reset did not load set value");

  AST_FLOP_EDGE_CAPTURE: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (!i_gsr && i_ce && !i_latch_mode && i_elem_clk && !st_r.clk_prev)
      |=> (o_q == $past(i_d)))
    else $error("flip-flop missed capture on enabled rising edge");

endmodule : ioc_storage

`default_nettype wire

// ---- logic/ioc_cell.sv ----
// module: io cell storage, selection and output multiplexer path
`default_nettype none

module ioc_cell
  import ioc_pkg::*;
(
  input  wire logic        i_core_clk,         // low-skew global clock
  input  wire logic        i_rst,              // async reset, active high
  input  wire logic        i_global_set_reset, // sync global set/reset
  input  wire logic        i_pad_in,           // level seen at the pad
  input  wire logic        i_early_clk,        // early clock level, sync
  input  wire logic        i_in_clk,           // input element clock level
  input  wire logic        i_out_clk,          // output clock level
  input  wire logic        i_out_data,         // output data from fabric
  input  wire logic        i_logic_cell_clock_enable, // shared enable
  input  wire logic        i_ce_connected,     // 0 = enable pin unconnected
  input  wire logic        i_cfg_early_capture,// use early capture latch
  input  wire logic        i_cfg_in_latch,     // input element as latch
  input  wire logic        i_cfg_out_latch,    // output element as latch
  input  wire logic        i_cfg_first_reg,    // first output registered
  input  wire logic        i_cfg_second_reg,   // second output registered
  input  wire ioc_pkg::ioc_ce_sel_e i_cfg_ce_sel, // enable target select
  input  wire logic        i_cfg_out_reg,      // pad data via out element
  input  wire logic        i_cfg_out_mux,      // enable clock-steered mux
  input  wire logic        i_cfg_out_and,      // mux acts as AND gate
  input  wire logic        i_cfg_in_set,       // input element sets on gsr
  input  wire logic        i_cfg_out_set,      // output element sets on gsr
  output logic             o_fabric_input_first,  // first input to fabric
  output logic             o_fabric_input_second, // second input to fabric
  output logic             o_pad_out              // data toward the pad
);
  import ioc_pkg::*;

  typedef struct packed {
    logic early_prev;
    logic capture;
    logic first;
    logic second;
    logic pad;
  } ioc_cell_s;

  ioc_cell_s st_r;
  ioc_cell_s st_nxt;

  logic ce_eff;
  logic ce_in;
  logic ce_out;
  logic in_d;
  logic in_q;
  logic out_q;
  logic out_src;

  ////////////////////////////////////////////////////////////////////////////
  // shared enable: no inversion here, invert in the fabric if needed
  assign ce_eff = i_ce_connected ? i_logic_cell_clock_enable
                                 : IOC_CE_UNCONNECTED;

  // an element not targeted by the enable runs as always enabled
  always_comb begin
    ce_in  = 1'h1;
    ce_out = 1'h1;
    unique case (i_cfg_ce_sel)
      IOC_CE_INPUT: begin
        ce_in = ce_eff;
      end
      IOC_CE_OUTPUT: begin
        ce_out = ce_eff;
      end
      IOC_CE_BOTH: begin
        ce_in  = ce_eff;
        ce_out = ce_eff;
      end
      IOC_CE_NONE: begin
        ce_in  = 1'h1;
        ce_out = 1'h1;
      end
    endcase
  end

  // input element reads the capture latch when early capture is on
  assign in_d = i_cfg_early_capture ? st_r.capture : i_pad_in;

  ////////////////////////////////////////////////////////////////////////////
  // input and output storage elements share one implementation
  ioc_storage u_in_elem (
    .i_core_clk   (i_core_clk),
    .i_rst        (i_rst),
    .i_elem_clk   (i_in_clk),
    .i_ce         (ce_in),
    .i_d          (in_d),
    .i_latch_mode (i_cfg_in_latch),
    .i_gsr        (i_global_set_reset),
    .i_set_val    (i_cfg_in_set),
    .o_q          (in_q)
  );

  ioc_storage u_out_elem (
    .i_core_clk   (i_core_clk),
    .i_rst        (i_rst),
    .i_elem_clk   (i_out_clk),
    .i_ce         (ce_out),
    .i_d          (i_out_data),
    .i_latch_mode (i_cfg_out_latch),
    .i_gsr        (i_global_set_reset),
    .i_set_val    (i_cfg_out_set),
    .o_q          (out_q)
  );

  assign out_src = i_cfg_out_reg ? out_q : i_out_data;

  ////////////////////////////////////////////////////////////////////////////
  // next state: capture latch, fabric selects and pad multiplexer.
  // outputs are registered, so the direct paths carry one cycle of delay
  always_comb begin
    st_nxt            = st_r;
    st_nxt.early_prev = i_early_clk;
    // capture on early clock rising edge, ahead of the global clock
    if (i_early_clk && !st_r.early_prev) begin
      st_nxt.capture = i_pad_in;
    end
    st_nxt.first  = i_cfg_first_reg  ? in_q : i_pad_in;
    st_nxt.second = i_cfg_second_reg ? in_q : i_pad_in;
    if (i_cfg_out_and) begin
      st_nxt.pad = out_src & ce_eff;
    end else if (i_cfg_out_mux) begin
      // two signals time-share the pad, split by output clock level
      st_nxt.pad = i_out_clk ? out_src : ce_eff;
    end else begin
      st_nxt.pad = out_src;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{early_prev: 1'h0, capture: IOC_RESET_VALUE,
                first: 1'h0, second: 1'h0, pad: 1'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_fabric_input_first  = st_r.first;
  assign o_fabric_input_second = st_r.second;
  assign o_pad_out             = st_r.pad;

  ////////////////////////////////////////////////////////////////////////////
  AST_EARLY_CAPTURE: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_early_clk && !st_r.early_prev) |=> (st_r.capture == $past(i_pad_in)))
    else $error("capture latch missed early clock edge");

  AST_MUX_BY_OUT_CLK: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_cfg_out_mux && !i_cfg_out_and)
      |=> (o_pad_out == ($past(i_out_clk) ? $past(out_src)
                                           : $past(ce_eff))))
    else $error("pad mux chose wrong source for output clock level");

  AST_AND_GATE: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_cfg_out_and |=> (o_pad_out == ($past(out_src) & $past(ce_eff))))
    else $error("pad and gate output wrong");

  AST_FIRST_SELECT: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !i_cfg_first_reg |=> (o_fabric_input_first == $past(i_pad_in)))
    else $error("first fabric input not direct pad signal");

  AST_SECOND_SELECT: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_cfg_second_reg |=> (o_fabric_input_second == $past(in_q)))
    else $error("second fabric input not registered signal");

  AST_CE_TARGET: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_cfg_ce_sel == IOC_CE_OUTPUT) |-> ce_in)
    else $error("input element gated by enable aimed at output");

  AST_NO_INVERSION: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_ce_connected && i_cfg_ce_sel == IOC_CE_BOTH)
      |-> (ce_in == i_logic_cell_clock_enable))
    else $error("clock enable inverted inside cell");

  AST_UNCONNECTED_HIGH: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !i_ce_connected |-> (ce_eff == 1'h1))
    else $error("unconnected clock enable not treated high");

  AST_GSR_INPUT: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_global_set_reset && i_cfg_first_reg) ##1 i_cfg_first_reg
      |=> (o_fabric_input_first == $past(i_cfg_in_set, 2)))
    else $error("input element missed set/reset value");

  AST_FIRST_REGISTERED: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_cfg_first_reg |=> (o_fabric_input_first == $past(in_q)))
    else $error("first fabric input not registered signal");

  AST_SECOND_DIRECT: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !i_cfg_second_reg |=> (o_fabric_input_second == $past(i_pad_in)))
    else $error("second fabric input not direct pad signal");

  AST_PAD_PLAIN: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (!i_cfg_out_mux && !i_cfg_out_and)
      |=> (o_pad_out == $past(out_src)))
    else $error("pad path altered with mux and gate both off");

  AST_CE_INPUT_ONLY: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_cfg_ce_sel == IOC_CE_INPUT) |-> ce_out)
    else $error("output element gated by enable aimed at input");

  // the global clock edge moves the captured value, not the live pad
  AST_EARLY_TO_ELEMENT: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_cfg_early_capture && !i_cfg_in_latch && !i_global_set_reset &&
     ce_in && i_in_clk && !u_in_elem.st_r.clk_prev)
      |=> (in_q == $past(st_r.capture)))
    else $error("input element did not take captured value");

  COV_EARLY: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_cfg_early_capture && i_early_clk && !st_r.early_prev);
  COV_MUX: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_cfg_out_mux && i_out_clk ##1 i_cfg_out_mux && !i_out_clk);
  COV_AND: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_cfg_out_and && o_pad_out);
  COV_HOLD: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce_connected && !i_logic_cell_clock_enable);

endmodule : ioc_cell

`default_nettype wire

// ---- bench/ioc_pad_model.sv ----
// pad side model: the outside world driving the pad level
`default_nettype none

module ioc_pad_model (
  input  wire logic i_level, // level the outside world wants
  output logic      o_pad    // level seen at the cell's pad input
);
  timeunit 1ns;
  timeprecision 1ns;

  // board delay keeps pad changes clear of the sampling clock edge
  // a continuous path also carries the level set at time zero
  assign #2 o_pad = i_level;
endmodule : ioc_pad_model

`default_nettype wire

// ---- bench/ioc_cell_bench.sv ----
// self-checking bench for the io cell storage path
`default_nettype none

module ioc_cell_bench
  import ioc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        global_set_reset, lvl, pad, erl, inc, outc, od, ce, cec, v, a;
  logic        c_ec, c_il, c_ol, c_fr, c_sr, c_or, c_mx, c_an;
  logic        c_is, c_os, f1, f2, po;
  ioc_ce_sel_e sel;
  int          err_count = 0;
  int          cmp_count = 0;
  logic [31:0] seed = 32'hF828340C;

  always #10 clk = ~clk;

  ioc_pad_model i_pad (.i_level(lvl), .o_pad(pad));

  ioc_cell i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_global_set_reset(global_set_reset),
    .i_pad_in(pad), .i_early_clk(erl), .i_in_clk(inc),
    .i_out_clk(outc), .i_out_data(od),
    .i_logic_cell_clock_enable(ce), .i_ce_connected(cec),
    .i_cfg_early_capture(c_ec), .i_cfg_in_latch(c_il),
    .i_cfg_out_latch(c_ol), .i_cfg_first_reg(c_fr),
    .i_cfg_second_reg(c_sr), .i_cfg_ce_sel(sel), .i_cfg_out_reg(c_or),
    .i_cfg_out_mux(c_mx), .i_cfg_out_and(c_an), .i_cfg_in_set(c_is),
    .i_cfg_out_set(c_os), .o_fabric_input_first(f1),
    .o_fabric_input_second(f2), .o_pad_out(po));

  ////////////////////////////////////////////////////////////////////////
  // random bits: shift register, fixed start so runs repeat
  function automatic logic rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[0];
  endfunction : rnd

  // element value after a clock with the enable low: frozen if targeted
  function automatic logic held(input logic is_out, input logic old,
                                input logic nu);
    logic tgt;
    tgt = (sel == IOC_CE_BOTH) ||
          (sel == (is_out ? IOC_CE_OUTPUT : IOC_CE_INPUT));
    return (tgt && ce === 1'h0 && cec === 1'h1) ? old : nu;
  endfunction : held

  task automatic chk(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  // inputs only move on falling edges, away from sampling
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {global_set_reset, lvl, erl, inc, outc, od, ce, c_ec, c_il, c_ol} = '0;
    {c_fr, c_sr, c_or, c_mx, c_an, c_is, c_os} = '0;
    cec = 1'h1;
    sel = IOC_CE_BOTH;
    step(3);
    chk("reset q", 1'h0, f1 | f2 | po);
    rst = 1'h0;
    // enable high, else the targeted input element never loads
    ce = 1'h1;
    // direct against registered, each output chosen on its own
    for (int i = 0; i < 16; i++) begin
      {v, c_fr, c_sr} = {rnd(), i[0], ~i[0]};
      {lvl, inc} = {v, 1'h1};
      step(2);
      {lvl, inc} = {~v, 1'h0};
      step(2);
      chk("first", i[0] ? v : ~v, f1);
      chk("second", i[0] ? ~v : v, f2);
    end
    // enable steering; last pass leaves the enable pin unconnected
    {c_sr, c_or} = 2'h3;
    for (int i = 0; i < 5; i++) begin
      sel = ioc_ce_sel_e'(i[1:0]);
      {cec, v} = {i != 4, rnd()};
      {ce, lvl, od, inc, outc} = {1'h1, v, v, 2'h3};
      step(2);
      chk("second", v, f2);
      {ce, lvl, od, inc, outc} = {1'h0, ~v, ~v, 2'h0};
      step(1);
      {inc, outc} = 2'h3;
      step(2);
      chk("second", held(1'h0, v, ~v), f2);
      chk("pad out", held(1'h1, v, ~v), po);
      {inc, outc} = 2'h0;
      step(1);
    end
    // set/reset beats a low enable; set value per element
    {cec, ce} = 2'h2;
    sel = IOC_CE_BOTH;
    for (int i = 0; i < 2; i++) begin
      {c_is, c_os, global_set_reset} = {i[0], ~i[0], 1'h1};
      step(1);
      global_set_reset = 1'h0;
      step(1);
      chk("second", i[0], f2);
      chk("pad out", ~i[0], po);
    end
    // latch mode: transparent while clock low, frozen by enable
    sel = IOC_CE_INPUT;
    {c_il, c_ol, ce, v} = {3'h7, rnd()};
    {lvl, od} = {v, v};
    step(2);
    chk("second", v, f2);
    chk("pad out", v, po);
    // enable low freezes the input latch, a high clock the output one
    {ce, lvl, od, outc} = {1'h0, ~v, ~v, 1'h1};
    step(2);
    chk("second", v, f2);
    chk("pad out", v, po);
    {c_il, c_ol, c_ec, ce, v} = {4'h3, rnd()};
    // early capture keeps the value from before the pad moved
    {lvl, erl} = {v, 1'h1};
    step(1);
    {lvl, erl, inc} = {~v, 1'h0, 1'h1};
    step(2);
    chk("second", v, f2);
    // direct data path, so the mux result shows one edge later
    {inc, c_ec, c_or, c_mx} = 4'h1;
    // output clock level picks data or enable for the pad
    for (int i = 0; i < 8; i++) begin
      {od, ce, outc} = {rnd(), rnd(), 1'h1};
      step(1);
      chk("pad out", od, po);
      outc = 1'h0;
      step(1);
      chk("pad out", ce, po);
    end
    // and gate wins over the mux; low select would show the enable
    c_an = 1'h1;
    for (int i = 0; i < 8; i++) begin
      a = rnd();
      {od, ce, outc} = {a, rnd(), rnd()};
      step(1);
      chk("pad out", a & ce, po);
    end
    results();
  end

  // a hung run still reaches the closing report
  initial begin
    #1000000;
    err_count++;
    results();
  end
endmodule : ioc_cell_bench

`default_nettype wire
